/* dv/sbgp_pin_model.sv */
`timescale 1ns/100ps
module sbgp_pin_model (
  // Pad drive from the port
  input wire sbgp_pkg::sbgp_drive_t pad,
  // Board side stimulus
  input wire logic [5:0] ext_val,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ttl_skew,
  // Pad receivers
  output sbgp_pkg::sbgp_sense_t sense
);
  import sbgp_pkg::*;
  logic [5:0] wire_lvl;
  // Undriven pins float to a board pull-up, never to the last value
  assign wire_lvl = (pad.oe & pad.out) | (~pad.oe & ((ext_en & ext_val) | ~ext_en));
  // Skew lets the two receivers disagree on chosen pins
  assign sense.schmitt = wire_lvl;
  assign sense.ttl = wire_lvl ^ ttl_skew;
endmodule

/* dv/tb.sv */
`timescale 1ns/100ps
module tb;
  import sbgp_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  sbgp_req_t req = '0;
  logic [5:0] rd_data_q;
  logic rd_valid_q;
  logic [5:0] thresh_ttl_q;
  logic [5:0] analog_q;
  logic [5:0] change_q;
  sbgp_sense_t pin_sense;
  sbgp_drive_t pad_q;
  logic [5:0] ext_val = 6'h00;
  logic [5:0] ext_en = 6'h00;
  logic [5:0] ttl_skew = 6'h00;
  int failures = 0;
  int cmp_count = 0;

  always #10 clock = ~clock;

  sbgp_port u_dut (.clock(clock), .rst_n(rst_n), .req(req), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .pin_sense(pin_sense), .pad_q(pad_q),
    .thresh_ttl_q(thresh_ttl_q), .analog_q(analog_q), .change_q(change_q));
  sbgp_pin_model u_pins (.pad(pad_q), .ext_val(ext_val), .ext_en(ext_en),
    .ttl_skew(ttl_skew), .sense(pin_sense));

  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [5:0] got, input logic [5:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Returns after the write has reached the pads
  task automatic wr(input sbgp_sel_t sel, input logic [5:0] d, input logic [5:0] m);
    @(negedge clock);
    req.wr = 1'b1;
    req.sel = sel;
    req.data = d;
    req.mask = m;
    @(negedge clock);
    req.wr = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input sbgp_sel_t sel, input logic [5:0] exp, input string what);
    int n = 0;
    @(negedge clock);
    req.rd = 1'b1;
    req.sel = sel;
    @(negedge clock);
    req.rd = 1'b0;
    while (n < 4 && rd_valid_q !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (rd_valid_q !== 1'b1) begin
      failures++;
      $display("MISMATCH at %0t: no read answer for %s", $time, what);
      end_of_test();
    end
    chk(rd_data_q, exp, what);
  endtask

  task automatic t_reset();
    chk(analog_q, 6'h3f, "analog after reset");
    chk(pad_q.oe, 6'h00, "oe after reset");
    rd(SBGP_SEL_DIR, 6'h3f, "dir after reset");
    rd(SBGP_SEL_LATCH, 6'h00, "latch after reset");
    rd(SBGP_SEL_LEVEL, 6'h00, "analog pins level");
    rd(sbgp_sel_t'(3'b111), 6'h00, "unmapped read");
    $display("Test reset done");
  endtask

  task automatic t_drive();
    wr(SBGP_SEL_DIR, 6'h00, 6'h3f);
    rd(SBGP_SEL_DIR, 6'h08, "dir bit 3 stuck");
    wr(SBGP_SEL_LATCH, 6'h15, 6'h3f);
    chk(pad_q.out, 6'h15, "push-pull out with analog set");
    chk(pad_q.oe, 6'h37, "oe with pin 3 input only");
    wr(SBGP_SEL_OD, 6'h3f, 6'h3f);
    chk(pad_q.out, 6'h00, "open-drain out");
    chk(pad_q.oe, 6'h22, "open-drain oe");
    wr(SBGP_SEL_SLEW, 6'h2a, 6'h3f);
    chk(pad_q.slew, 6'h2a, "slew select");
    wr(SBGP_SEL_LATCH, 6'h00, 6'h01);
    rd(SBGP_SEL_LATCH, 6'h14, "masked latch bit");
    wr(SBGP_SEL_OD, 6'h00, 6'h3f);
    wr(SBGP_SEL_DIR, 6'h3f, 6'h3f);
    chk(pad_q.oe, 6'h00, "all inputs");
    $display("Test drive done");
  endtask

  task automatic t_input();
    ext_en = 6'h3f;
    ext_val = 6'h21;
    // Direction stays all inputs before going digital
    wr(SBGP_SEL_ANALOG, 6'h00, 6'h3f);
    chk(analog_q, 6'h00, "analog cleared");
    rd(SBGP_SEL_LEVEL, 6'h21, "pin levels");
    ttl_skew = 6'h06;
    // No peripherals run here, so the switch is safe
    wr(SBGP_SEL_THRESH, 6'h04, 6'h3f);
    chk(thresh_ttl_q, 6'h04, "threshold select");
    rd(SBGP_SEL_LEVEL, 6'h25, "ttl receiver on pin 2");
    wr(SBGP_SEL_LEVEL, 6'h02, 6'h02);
    rd(SBGP_SEL_LATCH, 6'h27, "read-modify-write latch");
    wr(SBGP_SEL_ANALOG, 6'h01, 6'h3f);
    rd(SBGP_SEL_LEVEL, 6'h24, "analog pin 0 reads 0");
    @(negedge clock);
    ext_val = 6'h31;
    // Level and change register on the same edge, so the pulse shows one edge on
    @(negedge clock);
    chk(change_q, 6'h10, "change pulse");
    @(negedge clock);
    chk(change_q, 6'h00, "change pulse ends");
    $display("Test input done");
  endtask

  task automatic t_rereset();
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    chk(analog_q, 6'h3f, "analog after second reset");
    chk(thresh_ttl_q, 6'h00, "threshold after second reset");
    rd(SBGP_SEL_LATCH, 6'h00, "latch after second reset");
    $display("Test second reset done");
  endtask

  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_drive();
    t_input();
    t_rereset();
    end_of_test();
  end
endmodule

/* hdl/sbgp_defines.svh */
`ifndef SBGP_DEFINES_SVH
`define SBGP_DEFINES_SVH

// Port geometry
`define SBGP_WIDTH 6
`define SBGP_IN_ONLY_IDX 3

// Reset values
`define SBGP_RST_LATCH 6'h00
`define SBGP_RST_DIR 6'h3F
`define SBGP_RST_OPEN_DRAIN 6'h00
`define SBGP_RST_SLEW 6'h00
`define SBGP_RST_THRESH 6'h00
`define SBGP_RST_ANALOG 6'h3F
`define SBGP_ZERO 6'h00

`endif

/* hdl/sbgp_in_stage.sv */
`timescale 1ns/100ps
`include "sbgp_defines.svh"

module sbgp_in_stage
#(
  parameter int WIDTH = `SBGP_WIDTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pad receivers and selects
  input wire sbgp_pkg::sbgp_sense_t sense,
  input wire logic [WIDTH-1:0] thresh_ttl,
  input wire logic [WIDTH-1:0] analog,
  // Sampled digital levels and change pulse
  output logic [WIDTH-1:0] level_q,
  output logic [WIDTH-1:0] change_q
);
  import sbgp_pkg::*;

  logic [WIDTH-1:0] level_d;
  logic [WIDTH-1:0] change_d;

  always_comb begin
    level_d = (thresh_ttl & sense.ttl) | (~thresh_ttl & sense.schmitt);
    level_d = level_d & ~analog;
    // A threshold swap can flag a change with no real edge
    change_d = level_d ^ level_q;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      level_q <= `SBGP_ZERO;
      change_q <= `SBGP_ZERO;
    end else begin
      level_q <= level_d;
      change_q <= change_d;
    end
  end

  threshold_sample_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> level_q == ($past(~analog) & (($past(thresh_ttl) & $past(sense.ttl))
      | ($past(~thresh_ttl) & $past(sense.schmitt)))))
    else $error("sampled level does not follow threshold select");
endmodule

/* hdl/sbgp_pad_ctrl.sv */
`timescale 1ns/100ps
`include "sbgp_defines.svh"

module sbgp_pad_ctrl
#(
  parameter int IN_ONLY_IDX = `SBGP_IN_ONLY_IDX
) (
  // Configuration
  input wire logic [`SBGP_WIDTH-1:0] dir,
  input wire logic [`SBGP_WIDTH-1:0] latch,
  input wire logic [`SBGP_WIDTH-1:0] open_drain,
  input wire logic [`SBGP_WIDTH-1:0] slew,
  // Drive towards the pads
  output sbgp_pkg::sbgp_drive_t drive
);
  import sbgp_pkg::*;

  logic [`SBGP_WIDTH-1:0] enabled;

  always_comb begin
    // Analog select is deliberately absent here
    enabled = ~dir;
    enabled[IN_ONLY_IDX] = 1'b0;
    // Open-drain pins only sink; a latch 1 releases the pad
    drive.oe = enabled & (~open_drain | ~latch);
    drive.out = latch & ~open_drain;
    drive.slew = slew;
  end
endmodule

/* hdl/sbgp_pkg.sv */
`include "sbgp_defines.svh"

package sbgp_pkg;

  // Register selects for the plain access port
  typedef enum logic [2:0] {
    SBGP_SEL_LEVEL  = 3'b000,
    SBGP_SEL_LATCH  = 3'b001,
    SBGP_SEL_DIR    = 3'b010,
    SBGP_SEL_OD     = 3'b011,
    SBGP_SEL_SLEW   = 3'b100,
    SBGP_SEL_THRESH = 3'b101,
    SBGP_SEL_ANALOG = 3'b110
  } sbgp_sel_t;

  // Drive bundle towards the pads
  typedef struct packed {
    logic [`SBGP_WIDTH-1:0] out;
    logic [`SBGP_WIDTH-1:0] oe;
    logic [`SBGP_WIDTH-1:0] slew;
  } sbgp_drive_t;

  // Both input receivers of each pad
  typedef struct packed {
    logic [`SBGP_WIDTH-1:0] schmitt;
    logic [`SBGP_WIDTH-1:0] ttl;
  } sbgp_sense_t;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    sbgp_sel_t sel;
    logic [`SBGP_WIDTH-1:0] data;
    logic [`SBGP_WIDTH-1:0] mask;
  } sbgp_req_t;

endpackage

/* hdl/sbgp_port.sv */
`timescale 1ns/100ps
`include "sbgp_defines.svh"

// How it works
// - Six pins, each with its own direction, latch and configuration bits.
// - Direction bit 1 turns the pin driver off; pin is an input.
// - Direction bit 0 enables the driver and drives the latch bit.
// - Pin 3 never drives and its direction bit always reads 1.
// - Pin register reads give pin levels; writes go to the latch.
// - Pin register writes merge addressed bits into current pin levels.
// - Direction keeps controlling the driver even on analog pins.
// - Analog pins read 0 on digital reads.
// - Open-drain pins drive low for 0 and release for 1.
// - Without open-drain the pin drives push-pull.
// - Per-pin slew limit select passes to the driver.
// - Per-pin threshold select picks Schmitt or TTL for reads and changes.
// - Analog select forces digital reads to 0.
// - Analog select leaves the output drive untouched.
// - All analog select bits are set by reset.
module sbgp_port
  import sbgp_pkg::*;
#(
  parameter int IN_ONLY_IDX = `SBGP_IN_ONLY_IDX
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register access
  input wire sbgp_pkg::sbgp_req_t req,
  output logic [`SBGP_WIDTH-1:0] rd_data_q,
  output logic rd_valid_q,
  // Pad side
  input wire sbgp_pkg::sbgp_sense_t pin_sense,
  output sbgp_pkg::sbgp_drive_t pad_q,
  output logic [`SBGP_WIDTH-1:0] thresh_ttl_q,
  output logic [`SBGP_WIDTH-1:0] analog_q,
  output logic [`SBGP_WIDTH-1:0] change_q
);
  import sbgp_pkg::*;

  logic [`SBGP_WIDTH-1:0] latch_q;
  logic [`SBGP_WIDTH-1:0] latch_d;
  logic [`SBGP_WIDTH-1:0] dir_q;
  logic [`SBGP_WIDTH-1:0] dir_d;
  logic [`SBGP_WIDTH-1:0] od_q;
  logic [`SBGP_WIDTH-1:0] od_d;
  logic [`SBGP_WIDTH-1:0] slew_q;
  logic [`SBGP_WIDTH-1:0] slew_d;
  logic [`SBGP_WIDTH-1:0] thresh_ttl_d;
  logic [`SBGP_WIDTH-1:0] analog_d;
  logic [`SBGP_WIDTH-1:0] rd_data_d;
  logic rd_valid_d;
  logic [`SBGP_WIDTH-1:0] level;
  sbgp_drive_t pad_d;

  // Merge the addressed bits of a write into a base value
  function automatic logic [`SBGP_WIDTH-1:0] merge(
    input logic [`SBGP_WIDTH-1:0] base,
    input logic [`SBGP_WIDTH-1:0] data,
    input logic [`SBGP_WIDTH-1:0] mask
  );
    merge = (base & ~mask) | (data & mask);
  endfunction

  // Input-only pin keeps its direction bit pinned high
  function automatic logic [`SBGP_WIDTH-1:0] fix_dir(input logic [`SBGP_WIDTH-1:0] d);
    fix_dir = d;
    fix_dir[IN_ONLY_IDX] = 1'b1;
  endfunction

  // Pin receivers, threshold select and analog masking
  sbgp_in_stage #(
    .WIDTH(`SBGP_WIDTH)
  ) u_in_stage (
    .clock(clock),
    .rst_n(rst_n),
    .sense(pin_sense),
    .thresh_ttl(thresh_ttl_q),
    .analog(analog_q),
    .level_q(level),
    .change_q(change_q)
  );

  // Driver decode; registered below so pads see clean edges
  sbgp_pad_ctrl #(
    .IN_ONLY_IDX(IN_ONLY_IDX)
  ) u_pad_ctrl (
    .dir(dir_q),
    .latch(latch_q),
    .open_drain(od_q),
    .slew(slew_q),
    .drive(pad_d)
  );

  // Configuration and latch writes
  always_comb begin
    latch_d = latch_q;
    dir_d = dir_q;
    od_d = od_q;
    slew_d = slew_q;
    thresh_ttl_d = thresh_ttl_q;
    analog_d = analog_q;
    if (req.wr) begin
      unique case (req.sel)
        SBGP_SEL_LEVEL: begin
          // Base is the pin levels, so analog pins fold in as 0
          latch_d = merge(level & ~analog_q, req.data, req.mask);
        end
        SBGP_SEL_LATCH: begin
          latch_d = merge(latch_q, req.data, req.mask);
        end
        SBGP_SEL_DIR: begin
          dir_d = fix_dir(merge(dir_q, req.data, req.mask));
        end
        SBGP_SEL_OD: begin
          od_d = merge(od_q, req.data, req.mask);
        end
        SBGP_SEL_SLEW: begin
          slew_d = merge(slew_q, req.data, req.mask);
        end
        SBGP_SEL_THRESH: begin
          // Spurious change pulses are possible here; software avoids it
          thresh_ttl_d = merge(thresh_ttl_q, req.data, req.mask);
        end
        SBGP_SEL_ANALOG: begin
          analog_d = merge(analog_q, req.data, req.mask);
        end
        default: begin
          latch_d = latch_q;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      latch_q <= `SBGP_RST_LATCH;
      dir_q <= `SBGP_RST_DIR;
      od_q <= `SBGP_RST_OPEN_DRAIN;
      slew_q <= `SBGP_RST_SLEW;
      thresh_ttl_q <= `SBGP_RST_THRESH;
      analog_q <= `SBGP_RST_ANALOG;
    end else begin
      latch_q <= latch_d;
      dir_q <= dir_d;
      od_q <= od_d;
      slew_q <= slew_d;
      thresh_ttl_q <= thresh_ttl_d;
      analog_q <= analog_d;
    end
  end

  // Read path
  always_comb begin
    rd_data_d = `SBGP_ZERO;
    rd_valid_d = req.rd;
    if (req.rd) begin
      unique case (req.sel)
        SBGP_SEL_LEVEL: begin
          rd_data_d = level & ~analog_q;
        end
        SBGP_SEL_LATCH: begin
          rd_data_d = latch_q;
        end
        SBGP_SEL_DIR: begin
          rd_data_d = fix_dir(dir_q);
        end
        SBGP_SEL_OD: begin
          rd_data_d = od_q;
        end
        SBGP_SEL_SLEW: begin
          rd_data_d = slew_q;
        end
        SBGP_SEL_THRESH: begin
          rd_data_d = thresh_ttl_q;
        end
        SBGP_SEL_ANALOG: begin
          rd_data_d = analog_q;
        end
        default: begin
          rd_data_d = `SBGP_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data_q <= `SBGP_ZERO;
      rd_valid_q <= 1'b0;
      pad_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      pad_q <= pad_d;
    end
  end

  input_only_oe_a: assert property (@(posedge clock) disable iff (!rst_n)
    !pad_q.oe[IN_ONLY_IDX])
    else $error("input-only pin driven");

  dir_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.sel == SBGP_SEL_DIR |=> rd_valid_q && rd_data_q[IN_ONLY_IDX])
    else $error("input-only direction bit read as 0");

  input_dir_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 (pad_q.oe & $past(dir_q)) == `SBGP_ZERO)
    else $error("driver on for a pin set as input");

  push_pull_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 ((pad_q.oe ^ $past(~dir_q)) & $past(~od_q)) == `SBGP_ZERO
      || $past(dir_q[IN_ONLY_IDX]) == 1'b0)
    else $error("push-pull output enable not following direction");

  push_pull_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 ((pad_q.out ^ $past(latch_q)) & $past(~od_q)) == `SBGP_ZERO)
    else $error("push-pull pin not driving its latch");

  open_drain_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 (($past(od_q) & pad_q.out) | ($past(od_q & latch_q) & pad_q.oe)) == `SBGP_ZERO)
    else $error("open-drain pin sourcing current");

  analog_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 (pad_q.oe & $past(~dir_q & ~od_q & analog_q))
      == ($past(~dir_q & ~od_q & analog_q) & ~fix_dir(`SBGP_ZERO)))
    else $error("analog select disturbed the output drive");

  analog_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.sel == SBGP_SEL_LEVEL |=> (rd_data_q & $past(analog_q)) == `SBGP_ZERO)
    else $error("analog pin read as 1");

  analog_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(rst_n) |-> analog_q == `SBGP_RST_ANALOG)
    else $error("analog select not set after reset");

  rmw_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.wr && req.sel == SBGP_SEL_LEVEL |=> latch_q == merge($past(level & ~analog_q),
      $past(req.data), $past(req.mask)))
    else $error("pin register write did not merge into pin levels");

  latch_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.sel == SBGP_SEL_LATCH |=> rd_data_q == $past(latch_q))
    else $error("latch read did not return stored latch");

  slew_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 pad_q.slew == $past(slew_q))
    else $error("slew select not passed to driver");

  dir_pinned_a: assert property (@(posedge clock) disable iff (!rst_n)
    dir_q[IN_ONLY_IDX])
    else $error("input-only direction bit cleared");

  latch_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.wr && req.sel == SBGP_SEL_LATCH
      |=> ((latch_q ^ $past(latch_q)) & ~$past(req.mask)) == `SBGP_ZERO)
    else $error("unaddressed latch bit changed");

  latch_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.wr && req.sel == SBGP_SEL_LATCH
      |=> ((latch_q ^ $past(req.data)) & $past(req.mask)) == `SBGP_ZERO)
    else $error("latch write did not land");

  od_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.wr && req.sel == SBGP_SEL_OD
      |=> ((od_q ^ $past(req.data)) & $past(req.mask)) == `SBGP_ZERO)
    else $error("open-drain select write did not land");

  slew_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.wr && req.sel == SBGP_SEL_SLEW
      |=> ((slew_q ^ $past(req.data)) & $past(req.mask)) == `SBGP_ZERO)
    else $error("slew select write did not land");

  thresh_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.wr && req.sel == SBGP_SEL_THRESH
      |=> ((thresh_ttl_q ^ $past(req.data)) & $past(req.mask)) == `SBGP_ZERO)
    else $error("threshold select write did not land");

  analog_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.wr && req.sel == SBGP_SEL_ANALOG
      |=> ((analog_q ^ $past(req.data)) & $past(req.mask)) == `SBGP_ZERO)
    else $error("analog select write did not land");

  level_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.sel == SBGP_SEL_LEVEL |=> rd_data_q == $past(level & ~analog_q))
    else $error("pin register read did not return pin levels");

  read_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 rd_valid_q == $past(req.rd))
    else $error("read answer strobe not one cycle after request");

  reset_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(rst_n) |-> pad_q.oe == `SBGP_ZERO && dir_q == `SBGP_RST_DIR)
    else $error("pins not released as inputs after reset");

  analog_change_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n, 2) |-> (change_q & $past(analog_q) & $past(analog_q, 2)) == `SBGP_ZERO)
    else $error("analog pin flagged a change");

  change_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> change_q == (level ^ $past(level)))
    else $error("change pulse does not match sampled level edge");

  open_drain_sink_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 ((pad_q.oe ^ ($past(~dir_q & ~latch_q) & ~fix_dir(`SBGP_ZERO))) & $past(od_q))
      == `SBGP_ZERO)
    else $error("open-drain pin not sinking for latch 0");
endmodule
